//--- verilog/sfrb_params.svh
// constants for the serial flash read / buffer command link
// ---------------------------------------------------------------
// Operation
// RULE1 - low power read: 01h, three address bytes
// RULE2 - big pages: ten page bits, nine byte bits
// RULE3 - default pages: 18-bit address, ten page bits
// RULE4 - array read crosses pages without delay
// RULE5 - array read wraps at array end
// RULE6 - select rising ends read, output released
// RULE7 - array reads never alter the buffer
// RULE8 - page read: D2h, address, four dummy bytes
// RULE9 - page read reaches all 1024 pages
// RULE10 - page read wraps within its page
// RULE11 - buffer read opcodes D4h and D1h
// RULE12 - buffer read address carries dummy bits
// RULE13 - D4h adds one dummy byte, D1h none
// RULE14 - buffer read wraps at buffer end
// RULE15 - buffer write: 84h, address is first byte
// RULE16 - buffer write stores bytes, wraps, until deselect
// RULE17 - program command 83h with page address
// RULE18 - select rising: erase page, then program buffer
// RULE19 - ready flag low while sequence runs
// RULE20 - failed byte sets the error flag
// RULE21 - host keeps select low whole command
// RULE22 - mode 0, msb first, sample rise, drive fall
// ---------------------------------------------------------------
`ifndef SFRB_PARAMS_SVH
`define SFRB_PARAMS_SVH
`define SFRB_OP_LPREAD 8'h01
`define SFRB_OP_PGREAD 8'hd2
`define SFRB_OP_BUFRD_F 8'hd4
`define SFRB_OP_BUFRD_S 8'hd1
`define SFRB_OP_BUFWR 8'h84
`define SFRB_OP_PROG 8'h83
`define SFRB_ADDR_BYTES 2'd3
`define SFRB_PGRD_DUMMY 3'd4
`define SFRB_BUFRD_DUMMY 3'd1
`define SFRB_PAGES 1024
`define SFRB_PG_BIG 9'd264
`define SFRB_PG_STD 9'd256
`define SFRB_BIG_PG_LSB 9
`define SFRB_STD_PG_LSB 8
`define SFRB_ERASED 8'hff
`define SFRB_HALF_CYC 3'd4
`define SFRB_CS_GAP 3'd4
`define SFRB_FIFO_DEPTH 32
`endif

//--- verilog/sfrb_pkg.sv
// types shared by both ends of the serial flash link
package sfrb_pkg;
    typedef logic [7:0] sfrb_byte_t;
    typedef enum logic [3:0] {
        DS_CMD = 4'h0, DS_ADDR = 4'h1, DS_DUMMY = 4'h2, DS_RDATA = 4'h3,
        DS_WDATA = 4'h4, DS_HOLD = 4'h5, DS_IGNORE = 4'h6, DS_ERASE = 4'h7,
        DS_PROG = 4'h8, DS_VERIFY = 4'h9
    } sfrb_dstate_t;
    typedef enum logic [1:0] {
        HS_IDLE = 2'h0, HS_RUN = 2'h1, HS_GAP = 2'h2
    } sfrb_hstate_t;
    typedef struct packed {
        sfrb_dstate_t state;
        logic sck_q;
        logic cs_q;
        logic [7:0] sh;
        logic [2:0] bitn;
        logic [7:0] op;
        logic [8:0] cnt;
        logic [23:0] addr;
        logic [9:0] page;
        logic [8:0] col;
        logic [2:0] obit;
        logic so;
        logic so_oe;
        logic busy;
        logic err;
    } sfrb_dev_t;
    typedef struct packed {
        sfrb_hstate_t state;
        logic [2:0] div;
        logic sck;
        logic cs_n;
        logic mosi;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [2:0] bitn;
        logic [16:0] bi;
        logic [16:0] total;
        logic [2:0] nd;
        logic [7:0] op;
        logic [23:0] addr;
        logic isrd;
        logic iswr;
    } sfrb_host_t;
endpackage

//--- verilog/sfrb_link_if.sv
// serial link between host and flash device
interface sfrb_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    modport dev (input cs_n, input sck, input si, output so, output so_oe);
    modport host (output cs_n, output sck, output si, input so,
                  input so_oe);
endinterface

//--- verilog/sfrb_dev_end.sv
// flash device end: command decode, array, buffer, program sequence
`include "sfrb_params.svh"
module sfrb_dev_end (
    // link
    sfrb_link_if.dev link,
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // configuration and status
    input wire logic big_page_mode,
    output logic ready_busy_flag,
    output logic erase_program_error_flag
);
    import sfrb_pkg::*;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // column advance with wrap at the page or buffer size
    function automatic logic [8:0] col_next(input logic [8:0] c,
                                            input logic [8:0] psz);
        col_next = (c >= psz - 9'd1) ? 9'd0 : c + 9'd1;
    endfunction

    // number of dummy bytes after the address
    function automatic logic [2:0] dummies(input logic [7:0] o);
        if (o == `SFRB_OP_PGREAD) dummies = `SFRB_PGRD_DUMMY;
        else if (o == `SFRB_OP_BUFRD_F) dummies = `SFRB_BUFRD_DUMMY;
        else dummies = 3'd0;
    endfunction

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic [7:0] mem [0:`SFRB_PAGES-1][0:263];
    logic [7:0] bufm [0:263];
    sfrb_dev_t dev_ff;
    sfrb_dev_t nxt_dev;
    logic [8:0] psz;
    logic rise;
    logic fall;
    logic [7:0] b;
    logic [7:0] cur;
    logic mem_we;
    logic [9:0] mem_pg;
    logic [8:0] mem_col;
    logic [7:0] mem_wd;
    logic buf_we;
    logic [8:0] buf_wa;
    logic [7:0] buf_wd;
    logic isbuf;

    // page size follows the configuration pin
    assign psz = big_page_mode ? `SFRB_PG_BIG : `SFRB_PG_STD;
    assign rise = link.sck & ~dev_ff.sck_q;
    assign fall = ~link.sck & dev_ff.sck_q;
    assign b = {dev_ff.sh[6:0], link.si};
    assign isbuf = (dev_ff.op == `SFRB_OP_BUFRD_F) ||
                   (dev_ff.op == `SFRB_OP_BUFRD_S);
    // RULE7 array reads fetch from mem
    assign cur = isbuf ? bufm[dev_ff.col] : mem[dev_ff.page][dev_ff.col];

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        nxt_dev = dev_ff;
        nxt_dev.sck_q = link.sck;
        nxt_dev.cs_q = link.cs_n;
        mem_we = 1'b0;
        mem_pg = dev_ff.page;
        mem_col = dev_ff.cnt;
        mem_wd = `SFRB_ERASED;
        buf_we = 1'b0;
        buf_wa = dev_ff.col;
        buf_wd = b;
        case (dev_ff.state)
            // RULE18 erase page to all ones first
            DS_ERASE: begin
                mem_we = 1'b1;
                nxt_dev.cnt = dev_ff.cnt + 9'd1;
                if (dev_ff.cnt == psz - 9'd1) begin
                    nxt_dev.cnt = 9'd0;
                    nxt_dev.state = DS_PROG;
                end
            end
            // RULE18 then copy the buffer into it
            DS_PROG: begin
                mem_we = 1'b1;
                mem_wd = bufm[dev_ff.cnt];
                nxt_dev.cnt = dev_ff.cnt + 9'd1;
                if (dev_ff.cnt == psz - 9'd1) begin
                    nxt_dev.cnt = 9'd0;
                    nxt_dev.state = DS_VERIFY;
                end
            end
            // RULE20 readback compare flags bad bytes
            DS_VERIFY: begin
                if (mem[dev_ff.page][dev_ff.cnt] != bufm[dev_ff.cnt]) begin
                    nxt_dev.err = 1'b1;
                end
                nxt_dev.cnt = dev_ff.cnt + 9'd1;
                if (dev_ff.cnt == psz - 9'd1) begin
                    nxt_dev.busy = 1'b0;
                    nxt_dev.state = DS_IGNORE;
                end
            end
            default: begin
                if (link.cs_n) begin
                    // RULE6 deselect ends the command, output released
                    nxt_dev.so_oe = 1'b0;
                    nxt_dev.bitn = 3'd0;
                    nxt_dev.state = DS_CMD;
                    // RULE18 program starts on select rising
                    if (dev_ff.state == DS_HOLD && !dev_ff.cs_q) begin
                        nxt_dev.busy = 1'b1;
                        nxt_dev.err = 1'b0;
                        nxt_dev.cnt = 9'd0;
                        nxt_dev.state = DS_ERASE;
                    end
                end else if (rise) begin
                    // RULE22 sample input on rising edge, msb first
                    nxt_dev.sh = b;
                    nxt_dev.bitn = dev_ff.bitn + 3'd1;
                    if (dev_ff.bitn == 3'd7) begin
                        case (dev_ff.state)
                            DS_CMD: begin
                                nxt_dev.op = b;
                                nxt_dev.cnt = 9'd0;
                                // RULE11 both buffer read opcodes
                                if (b == `SFRB_OP_LPREAD ||
                                    b == `SFRB_OP_PGREAD ||
                                    b == `SFRB_OP_BUFRD_F ||
                                    b == `SFRB_OP_BUFRD_S ||
                                    b == `SFRB_OP_BUFWR ||
                                    b == `SFRB_OP_PROG) begin
                                    nxt_dev.state = DS_ADDR;
                                end else begin
                                    nxt_dev.state = DS_IGNORE;
                                end
                            end
                            DS_ADDR: begin
                                nxt_dev.addr = {dev_ff.addr[15:0], b};
                                nxt_dev.cnt = dev_ff.cnt + 9'd1;
                                if (dev_ff.cnt == 9'(`SFRB_ADDR_BYTES - 1))
                                begin
                                    nxt_dev.cnt = 9'd0;
                                    nxt_dev.obit = 3'd0;
                                    // RULE2 big pages: ten page, nine byte bits
                                    // RULE9 any of the 1024 pages
                                    // last byte not in addr yet: drop 8
                                    if (big_page_mode) begin
                                        nxt_dev.page = dev_ff.addr
                                            [`SFRB_BIG_PG_LSB - 8 +: 10];
                                        nxt_dev.col = {dev_ff.addr[0], b};
                                    end else begin
                                        // RULE3 18-bit address split 10/8
                                        nxt_dev.page = dev_ff.addr
                                            [`SFRB_STD_PG_LSB - 8 +: 10];
                                        nxt_dev.col = {1'b0, b};
                                    end
                                    if (dev_ff.op == `SFRB_OP_PROG) begin
                                        nxt_dev.state = DS_HOLD;
                                    end else if (dev_ff.op == `SFRB_OP_BUFWR)
                                    begin
                                        // RULE15 address is first byte
                                        nxt_dev.state = DS_WDATA;
                                    end else if (dummies(dev_ff.op) == 3'd0)
                                    begin
                                        // RULE1 data follows address
                                        // RULE13 D1h has no dummy byte
                                        nxt_dev.state = DS_RDATA;
                                    end else begin
                                        nxt_dev.state = DS_DUMMY;
                                    end
                                end
                            end
                            // RULE8 data only after the dummy bytes
                            DS_DUMMY: begin
                                nxt_dev.cnt = dev_ff.cnt + 9'd1;
                                if (dev_ff.cnt[2:0] ==
                                    dummies(dev_ff.op) - 3'd1) begin
                                    nxt_dev.state = DS_RDATA;
                                end
                            end
                            // RULE16 store byte, advance, wrap at end
                            DS_WDATA: begin
                                buf_we = 1'b1;
                                nxt_dev.col = col_next(dev_ff.col, psz);
                            end
                            default: begin
                            end
                        endcase
                    end
                end else if (fall && dev_ff.state == DS_RDATA) begin
                    // RULE22 output changes on falling edge
                    nxt_dev.so = cur[3'd7 - dev_ff.obit];
                    nxt_dev.so_oe = 1'b1;
                    nxt_dev.obit = dev_ff.obit + 3'd1;
                    if (dev_ff.obit == 3'd7) begin
                        nxt_dev.col = col_next(dev_ff.col, psz);
                        // RULE4 next page with no added delay
                        // RULE5 page counter wraps to page zero
                        if (dev_ff.op == `SFRB_OP_LPREAD &&
                            dev_ff.col >= psz - 9'd1) begin
                            nxt_dev.page = dev_ff.page + 10'd1;
                        end
                        // RULE10 page read keeps its page
                        // RULE14 buffer read wraps at buffer end
                    end
                end
            end
        endcase
    end


    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dev_ff <= '0;
            dev_ff.sck_q <= 1'b0;
            dev_ff.cs_q <= 1'b1;
            dev_ff.state <= DS_CMD;
        end else begin
            dev_ff <= nxt_dev;
        end
    end

    // array and buffer have no reset: contents survive reset
    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            mem[mem_pg][mem_col] <= mem_wd;
        end
        if (buf_we) begin
            bufm[buf_wa] <= buf_wd;
        end
    end

    // link and status outputs straight from flops
    assign link.so = dev_ff.so;
    assign link.so_oe = dev_ff.so_oe;
    // RULE19 ready flag low while busy
    assign ready_busy_flag = ~dev_ff.busy;
    assign erase_program_error_flag = dev_ff.err;
endmodule

//--- verilog/sfrb_host_end.sv
// host end: command sequencer with read-data fifo
`include "sfrb_params.svh"
module sfrb_fifo #(
    parameter int W = 8,
    parameter int D = `SFRB_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sfrb_fifo_t;
    sfrb_fifo_t f_ff;
    sfrb_fifo_t nxt_f;
    logic [W-1:0] mem [0:D-1];
    logic push;
    logic pop;

    // honest flags from the word count
    assign in_ready = (f_ff.cnt != (AW+1)'(D));
    assign out_valid = (f_ff.cnt != '0);
    assign out_data = mem[f_ff.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // pointer update, pointers wrap at the depth
    always_comb begin
        nxt_f = f_ff;
        if (push) nxt_f.wp = (f_ff.wp == AW'(D - 1)) ? '0 : f_ff.wp + 1'b1;
        if (pop) nxt_f.rp = (f_ff.rp == AW'(D - 1)) ? '0 : f_ff.rp + 1'b1;
        nxt_f.cnt = f_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) f_ff <= '0;
        else f_ff <= nxt_f;
    end

    always_ff @(posedge clk_sys) begin
        if (push) mem[f_ff.wp] <= in_data;
    end
endmodule

module sfrb_host_end (
    // link
    sfrb_link_if.host link,
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // command request
    input wire logic req_valid,
    output logic req_ready,
    input wire sfrb_pkg::sfrb_byte_t req_opcode,
    input wire logic [23:0] req_addr,
    input wire logic [15:0] req_len,
    // write data
    input wire logic wr_valid,
    output logic wr_ready,
    input wire sfrb_pkg::sfrb_byte_t wr_data,
    // read data
    output logic rd_valid,
    input wire logic rd_ready,
    output sfrb_pkg::sfrb_byte_t rd_data,
    // status
    output logic host_busy
);
    import sfrb_pkg::*;

    sfrb_host_t h_ff;
    sfrb_host_t nxt_h;
    logic tick;
    logic push;
    logic fifo_rdy;
    logic last;
    logic rdbyte;
    logic needwr;
    logic [16:0] nb_i;
    logic [16:0] hdr;
    logic [7:0] nb;

    // byte to send at a given frame position
    function automatic logic [7:0] frame_byte(input logic [16:0] i,
        input sfrb_host_t h, input logic [7:0] wd);
        if (i == 17'd1) frame_byte = h.addr[23:16];
        else if (i == 17'd2) frame_byte = h.addr[15:8];
        else if (i == 17'd3) frame_byte = h.addr[7:0];
        else if (i < 17'd4 + 17'(h.nd) || !h.iswr) frame_byte = 8'h00;
        else frame_byte = wd;
    endfunction

    assign tick = (h_ff.div == `SFRB_HALF_CYC - 3'd1);
    assign hdr = 17'd4 + 17'(h_ff.nd);
    assign last = (h_ff.bitn == 3'd7);
    assign nb_i = h_ff.bi + 17'd1;
    assign rdbyte = last & h_ff.isrd & (h_ff.bi >= hdr);
    assign needwr = last & h_ff.iswr & (nb_i >= hdr) & (nb_i < h_ff.total);
    assign nb = frame_byte(nb_i, h_ff, wr_data);
    assign req_ready = (h_ff.state == HS_IDLE);
    assign host_busy = (h_ff.state != HS_IDLE);

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb begin
        nxt_h = h_ff;
        push = 1'b0;
        wr_ready = 1'b0;
        nxt_h.div = tick ? 3'd0 : h_ff.div + 3'd1;
        case (h_ff.state)
            HS_IDLE: begin
                if (req_valid) begin
                    // RULE21 select held low for the whole frame
                    nxt_h.cs_n = 1'b0;
                    nxt_h.op = req_opcode;
                    nxt_h.addr = req_addr;
                    // RULE13 one dummy byte for D4h only
                    if (req_opcode == `SFRB_OP_PGREAD)
                        nxt_h.nd = `SFRB_PGRD_DUMMY;
                    else if (req_opcode == `SFRB_OP_BUFRD_F)
                        nxt_h.nd = `SFRB_BUFRD_DUMMY;
                    else
                        nxt_h.nd = 3'd0;
                    nxt_h.iswr = (req_opcode == `SFRB_OP_BUFWR);
                    nxt_h.isrd = (req_opcode == `SFRB_OP_LPREAD) ||
                        (req_opcode == `SFRB_OP_PGREAD) ||
                        (req_opcode == `SFRB_OP_BUFRD_F) ||
                        (req_opcode == `SFRB_OP_BUFRD_S);
                    nxt_h.total = 17'd4 + 17'(nxt_h.nd) + 17'(req_len);
                    nxt_h.bi = 17'd0;
                    nxt_h.bitn = 3'd0;
                    nxt_h.tx = req_opcode;
                    nxt_h.mosi = req_opcode[7];
                    nxt_h.div = 3'd0;
                    nxt_h.state = HS_RUN;
                end
            end
            HS_RUN: begin
                if (tick && !h_ff.sck) begin
                    // RULE22 sample device output on rising edge
                    nxt_h.sck = 1'b1;
                    nxt_h.rx = {h_ff.rx[6:0], link.so};
                end else if (tick) begin
                    // a full fifo or missing write data holds the clock
                    if (!((rdbyte && !fifo_rdy) || (needwr && !wr_valid)))
                    begin
                        nxt_h.sck = 1'b0;
                        push = rdbyte;
                        nxt_h.bitn = h_ff.bitn + 3'd1;
                        nxt_h.tx = {h_ff.tx[6:0], 1'b0};
                        nxt_h.mosi = h_ff.tx[6];
                        if (last) begin
                            nxt_h.bi = nb_i;
                            wr_ready = needwr;
                            nxt_h.tx = nb;
                            nxt_h.mosi = nb[7];
                            if (nb_i == h_ff.total) begin
                                nxt_h.cs_n = 1'b1;
                                nxt_h.bitn = 3'd0;
                                nxt_h.state = HS_GAP;
                            end
                        end
                    end
                end
            end
            default: begin
                // deselect time between frames
                if (tick) begin
                    nxt_h.bitn = h_ff.bitn + 3'd1;
                    if (h_ff.bitn == `SFRB_CS_GAP - 3'd1)
                        nxt_h.state = HS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            h_ff <= '0;
            h_ff.cs_n <= 1'b1;
            h_ff.state <= HS_IDLE;
        end else begin
            h_ff <= nxt_h;
        end
    end

    // read bytes queue here; back-pressure stalls the link clock
    sfrb_fifo #(.W(8), .D(`SFRB_FIFO_DEPTH)) u_rdq (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(push),
        .in_ready(fifo_rdy),
        .in_data(h_ff.rx),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );

    assign link.cs_n = h_ff.cs_n;
    assign link.sck = h_ff.sck;
    assign link.si = h_ff.mosi;
endmodule

//--- tb/sfrb_properties.sv
// link checker for the serial flash host and device ends
module sfrb_properties (
    // clock, reset and link
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe
);
    logic [7:0] op_ff;
    logic [9:0] rise_ff;
    logic sck_ff;
    // rises per frame; first eight bits kept as opcode
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            {op_ff, rise_ff, sck_ff} <= '0;
        end else begin
            sck_ff <= sck;
            rise_ff <= cs_n ? '0 : rise_ff + 10'(sck & !sck_ff);
            if (sck && !sck_ff && rise_ff < 10'd8) begin
                op_ff <= {op_ff[6:0], si};
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // two edges deselected, past the one-cycle lag
    sequence s_idle2;
        cs_n [*2];
    endsequence
    property p_start(logic [7:0] op, logic [9:0] n);
        $rose(so_oe) && op_ff == op |-> rise_ff == n;
    endproperty
    a_oe_deselect: assert property (s_idle2 |-> !so_oe)
        else $error("so driven while deselected");
    a_sck_idle_low: assert property (s_idle2 |-> !sck)
        else $error("sck high while deselected");
    a_so_hold_high: assert property (
        so_oe && sck && $past(sck) |-> $stable(so))
        else $error("so moved while sck high");
    a_si_hold_rise: assert property ($rose(sck) |-> $stable(si))
        else $error("si moved at sck rise");
    a_lp_no_dummy: assert property (p_start(8'h01, 10'd32))
        else $error("low power read starts at wrong bit");
    a_pg_four_dummy: assert property (p_start(8'hd2, 10'd64))
        else $error("page read starts at wrong bit");
    a_bufrd_dummy: assert property (p_start(8'hd4, 10'd40))
        else $error("buffer read starts at wrong bit");
    a_bufrd_direct: assert property (p_start(8'hd1, 10'd32))
        else $error("slow buffer read starts at wrong bit");
endmodule

//--- tb/sfrb_test.sv
// bench joining both link ends of the serial flash
module sfrb_test;
    timeunit 1ns;
    timeprecision 1ns;
    import sfrb_pkg::*;
    logic clk_sys = 0, resetn = 0, req_valid = 0, rd_ready = 1, big = 0;
    logic req_ready, wr_ready, rd_valid, host_busy, rdy, err;
    sfrb_byte_t req_opcode = '0, wr_data, rd_data;
    logic [23:0] req_addr = '0;
    logic [15:0] req_len = '0;
    logic [8:0] wk = '0;
    sfrb_byte_t got[$];
    int error_cnt = 0, comparisons = 0, cyc = 0;
    sfrb_link_if link();
    sfrb_dev_end u_sfrb_dev_end (.link(link.dev), .clk_sys, .resetn,
        .big_page_mode(big), .ready_busy_flag(rdy),
        .erase_program_error_flag(err));
    sfrb_host_end u_sfrb_host_end (.link(link.host), .clk_sys, .resetn,
        .req_valid, .req_ready, .req_opcode, .req_addr, .req_len,
        .wr_valid(1'b1), .wr_ready, .wr_data, .rd_valid, .rd_ready,
        .rd_data, .host_busy);
    sfrb_properties u_sfrb_properties (.clk_sys, .resetn, .cs_n(link.cs_n),
        .sck(link.sck), .si(link.si), .so(link.so), .so_oe(link.so_oe));
    // byte k carries k plus its ninth bit, so a wrap shows
    assign wr_data = wk[7:0] + {7'h0, wk[8]};
    initial forever #10 clk_sys = ~clk_sys;
    // gather read bytes, step write data, cut a hang short
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        wk <= wr_ready ? wk + 9'h1 : wk;
        if (rd_valid && rd_ready) got.push_back(rd_data);
        if (cyc == 90000) begin
            error_cnt++;
            results();
        end
    end
    task automatic results();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // buffer byte p after a 258-byte write from 0
    function automatic logic [7:0] ev(input logic [7:0] p);
        return p < 8'h2 ? p + 8'h1 : p;
    endfunction
    // one frame; returns once the host is idle again
    task automatic cmd(input sfrb_byte_t op, input logic [23:0] a,
                       input logic [15:0] n);
        got = {};
        @(negedge clk_sys);
        {req_opcode, req_addr, req_len, req_valid} = {op, a, n, 1'b1};
        @(negedge clk_sys);
        req_valid = 0;
        chk(req_ready, 1'b0);
        for (int t = 0; t < 40000 && host_busy !== 1'b0; t++)
            @(negedge clk_sys);
    endtask
    task automatic rd_chk(input sfrb_byte_t op, input logic [23:0] a,
                          input logic [15:0] n);
        cmd(op, a, n);
        chk(8'(got.size()), n[7:0]);
        chk(8'(got.size() >> 8), n[15:8]);
        foreach (got[i]) chk(got[i], ev(a[7:0] + i[7:0]));
    endtask
    task automatic t_buf();
        cmd(8'h84, 24'h0, 16'd258);
        rd_chk(8'hd4, 24'hfe, 16'd4);
    endtask
    task automatic t_prog(input logic [9:0] pg);
        cmd(8'h83, {6'h0, pg, 8'h0}, 16'd0);
        chk(rdy, 1'b0);
        for (int t = 0; t < 5000 && rdy !== 1'b1; t++) @(negedge clk_sys);
        chk(rdy, 1'b1);
        chk(err, 1'b0);
    endtask
    // last page into page 0 with the read fifo stalled full
    task automatic t_array();
        rd_ready = 0;
        fork
            rd_chk(8'h01, {6'h0, 10'h3ff, 8'h0}, 16'd300);
            begin
                repeat (3000) @(negedge clk_sys);
                rd_ready = 1;
            end
        join
    endtask
    task automatic t_page();
        rd_chk(8'hd2, 24'hfa, 16'd10);
        rd_chk(8'hd1, 24'h0, 16'd2);
    endtask
    // big pages: bytes 258 on carry 3,4,5,6; write wraps at 264
    task automatic t_big();
        big = 1;
        cmd(8'h84, 24'h106, 16'd4);
        cmd(8'hd1, 24'h106, 16'd4);
        chk(8'(got.size()), 8'h4);
        foreach (got[i]) chk(got[i], 8'(i + 3));
        big = 0;
    endtask
    initial begin
        repeat (4) @(negedge clk_sys);
        resetn = 1;
        t_buf();
        t_prog(10'h3ff);
        t_prog(10'h0);
        t_array();
        t_page();
        t_big();
        results();
    end
endmodule
